// [core/ifc_pkg.sv]
// constants shared by the interrupt request flag block
package ifc_pkg;
   localparam int           IFC_LINES    = 8;
   localparam int           IFC_AW       = 8;
   localparam int           IFC_DW       = 32;
   // register byte addresses
   localparam logic [7:0]   IFC_A_FLAG   = 8'h00;
   localparam logic [7:0]   IFC_A_SENSE  = 8'h04;
   localparam logic [7:0]   IFC_A_EVT    = 8'h08;
   localparam logic [7:0]   IFC_A_MASK   = 8'h0C;
   // sense field: two bits per line, low bit at 2n
   localparam int           IFC_SNS_W    = 2;
   localparam int           IFC_SNS_LO   = 0;
   localparam int           IFC_SNS_HI   = 1;
   localparam logic [1:0]   IFC_SNS_RST  = 2'h0;
   localparam logic [7:0]   IFC_FLAG_RST = 8'h00;
   localparam logic [7:0]   IFC_MASK_RST = 8'h00;
   localparam logic [31:0]  IFC_RD_ZERO  = 32'h0000_0000;
   // detection modes
   typedef enum logic [1:0] {
      IFC_LOW_LEVEL,
      IFC_FALL_EDGE,
      IFC_RISE_EDGE,
      IFC_BOTH_EDGE
   } ifc_sense_e;
endpackage

// [core/ifc_flag_clear.sv]
// per-line external interrupt request flags with set and clear logic
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
module ifc_flag_clear
#(
   parameter int NL = ifc_pkg::IFC_LINES
)
(
   // clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst_b,
   // standby pin and interrupt pins
   input  wire logic                        hw_standby,
   input  wire logic [NL-1:0]               external_interrupt_line,
   // exception sequencer
   input  wire logic                        exc_take,
   input  wire logic [$clog2(NL)-1:0]       exc_line,
   // data transfer controller
   input  wire logic                        dtc_act,
   input  wire logic [$clog2(NL)-1:0]       dtc_line,
   input  wire logic                        transfer_interrupt_select,
   // register port
   input  wire logic [ifc_pkg::IFC_AW-1:0]  reg_addr,
   input  wire logic [ifc_pkg::IFC_DW-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [ifc_pkg::IFC_DW-1:0]  reg_rdata,
   // flags to priority logic and interrupt out
   output logic      [NL-1:0]               line_request_flag,
   output logic                             irq
);
   import ifc_pkg::*;

   localparam int SW = NL * IFC_SNS_W;

   logic [NL-1:0] pin_s1;
   logic [NL-1:0] pin_s2;
   logic [NL-1:0] pin_prev;
   logic          stby_s1;
   logic          stby_s2;
   logic [SW-1:0] sense;
   logic [NL-1:0] armed;
   logic [NL-1:0] evt;
   logic [NL-1:0] mask;
   logic [NL-1:0] next_flag;
   logic [NL-1:0] set_c;
   logic [NL-1:0] clr_c;
   logic [NL-1:0] rise_c;
   logic          sel_flag;
   logic          sel_sense;
   logic          sel_evt;
   logic          sel_mask;

   assign sel_flag  = (reg_addr == IFC_A_FLAG);
   assign sel_sense = (reg_addr == IFC_A_SENSE);
   assign sel_evt   = (reg_addr == IFC_A_EVT);
   assign sel_mask  = (reg_addr == IFC_A_MASK);

   // pins and standby come from outside the clock domain
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_s1   <= '1;
         pin_s2   <= '1;
         pin_prev <= '1;
         stby_s1  <= 1'b0;
         stby_s2  <= 1'b0;
      end
      else
      begin
         pin_s1   <= external_interrupt_line;
         pin_s2   <= pin_s1;
         pin_prev <= pin_s2;
         stby_s1  <= hw_standby;
         stby_s2  <= stby_s1;
      end
   end

   // sense selection register
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         sense <= {NL{IFC_SNS_RST}};
      else if (reg_wr && sel_sense)
         sense <= reg_wdata[SW-1:0];
   end

   // per-line set and clear conditions
   genvar n;
   generate
      for (n = 0; n < NL; n++)
      begin : g_line
         ifc_sense_e md;
         logic       fall;
         logic       rise;
         logic       hit;
         logic       exc_n;
         logic       dtc_n;
         logic       wclr;
         assign md   = ifc_sense_e'(sense[n*IFC_SNS_W +: IFC_SNS_W]);
         assign fall = pin_prev[n] & ~pin_s2[n];
         assign rise = ~pin_prev[n] & pin_s2[n];
         always_comb
         begin
            hit = 1'b0;
            case (md)
               IFC_LOW_LEVEL: hit = ~pin_s2[n];
               IFC_FALL_EDGE: hit = fall;
               IFC_RISE_EDGE: hit = rise;
               IFC_BOTH_EDGE: hit = fall | rise;
               default:       hit = 1'b0;
            endcase
         end
         assign set_c[n] = hit;
         assign exc_n = exc_take && (exc_line == n);
         assign dtc_n = dtc_act && (dtc_line == n)
                        && !transfer_interrupt_select;
         // writing one is ignored; zero clears only when armed
         assign wclr = reg_wr && sel_flag && !reg_wdata[n]
                       && armed[n];
         assign clr_c[n] = wclr
                         || (exc_n && md == IFC_LOW_LEVEL
                             && pin_s2[n])
                         || (exc_n && md != IFC_LOW_LEVEL)
                         || dtc_n;
      end
   endgenerate

   // a new request wins over a clear in the same cycle
   assign next_flag = set_c | (line_request_flag & ~clr_c);

   // a flag held clear by standby never rises, so it raises no event
   assign rise_c = stby_s2 ? {NL{1'b0}} : (next_flag & ~line_request_flag);

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         line_request_flag <= IFC_FLAG_RST;
      else if (stby_s2)
         line_request_flag <= IFC_FLAG_RST;
      else
         line_request_flag <= next_flag;
   end

   // read of a set flag arms it for a later zero write
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         armed <= '0;
      else if (stby_s2)
         armed <= '0;
      else if (reg_rd && sel_flag)
         armed <= line_request_flag;
      else if (reg_wr && sel_flag)
         armed <= '0;
      else
         armed <= armed & line_request_flag;
   end

   // sticky event bits: a flag going high; read clears, set wins
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         evt <= '0;
      else if (reg_rd && sel_evt)
         evt <= rise_c;
      else
         evt <= evt | rise_c;
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         mask <= IFC_MASK_RST;
      else if (reg_wr && sel_mask)
         mask <= reg_wdata[NL-1:0];
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         irq <= 1'b0;
      else
         irq <= |(evt & mask);
   end

   // read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         reg_rdata <= IFC_RD_ZERO;
      else if (!reg_rd)
         reg_rdata <= IFC_RD_ZERO;
      else if (sel_flag)
         reg_rdata <= {{(IFC_DW-NL){1'b0}}, line_request_flag};
      else if (sel_sense)
         reg_rdata <= {{(IFC_DW-SW){1'b0}}, sense};
      else if (sel_evt)
         reg_rdata <= {{(IFC_DW-NL){1'b0}}, evt};
      else if (sel_mask)
         reg_rdata <= {{(IFC_DW-NL){1'b0}}, mask};
      else
         reg_rdata <= IFC_RD_ZERO;
   end

   // checks on line 0; the standby, interrupt and read data checks cover all lines
   logic rise_seen0;
   assign rise_seen0 = ~pin_prev[0] & pin_s2[0];

   sequence rd_set0_s;
      reg_rd && sel_flag && line_request_flag[0];
   endsequence
   sequence hold0_s;
      !reg_rd && !reg_wr && line_request_flag[0];
   endsequence
   sequence wr_zero0_s;
      reg_wr && sel_flag && !reg_wdata[0];
   endsequence

   // read, one idle cycle with the flag still set, then the zero write
   arm_then_clear_a: assert property (
      @(posedge core_clk) disable iff (!rst_b || stby_s2)
      rd_set0_s ##1 hold0_s ##1 wr_zero0_s ##0 !set_c[0]
      |=> !line_request_flag[0])
      else $error("armed zero write did not clear");

   unarmed_keep_a: assert property (
      @(posedge core_clk) disable iff (!rst_b || stby_s2)
      wr_zero0_s ##0 (!armed[0] && !exc_take && !dtc_act
                      && line_request_flag[0])
      |=> line_request_flag[0])
      else $error("unarmed zero write cleared flag");

   one_write_a: assert property (
      @(posedge core_clk) disable iff (!rst_b || stby_s2)
      reg_wr && sel_flag && reg_wdata[0] && line_request_flag[0]
      && !exc_take && !dtc_act |=> line_request_flag[0])
      else $error("write of one disturbed flag");

   exc_low_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      exc_take && exc_line == 0 && sense[1:0] == IFC_SNS_RST
      && pin_s2[0] |=> !line_request_flag[0])
      else $error("low mode handling did not clear");

   exc_edge_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      exc_take && exc_line == 0 && sense[1:0] != IFC_SNS_RST
      && !set_c[0] |=> !line_request_flag[0])
      else $error("edge mode handling did not clear");

   dtc_clear_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      dtc_act && dtc_line == 0 && !transfer_interrupt_select
      && !set_c[0] |=> !line_request_flag[0])
      else $error("transfer activation did not clear");

   low_set_a: assert property (
      @(posedge core_clk) disable iff (!rst_b || stby_s2)
      sense[1:0] == IFC_SNS_RST && !pin_s2[0] |=> line_request_flag[0])
      else $error("low level did not set flag");

   fall_set_a: assert property (
      @(posedge core_clk) disable iff (!rst_b || stby_s2)
      ifc_sense_e'(sense[1:0]) == IFC_FALL_EDGE
      && pin_prev[0] && !pin_s2[0]
      |=> line_request_flag[0])
      else $error("falling edge did not set flag");

   // the mode must have stood a cycle, else the old mode set the flag
   rise_only_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      ifc_sense_e'(sense[1:0]) == IFC_RISE_EDGE
      && $past(sense[1:0]) == sense[1:0]
      && !$past(line_request_flag[0])
      && line_request_flag[0] && !$past(stby_s2)
      |-> $past(rise_seen0))
      else $error("rising mode set without rising edge");

   stby_clear_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      stby_s2 |=> line_request_flag == IFC_FLAG_RST)
      else $error("standby did not clear flags");

   irq_level_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      |(evt & mask) |=> irq)
      else $error("interrupt not raised");

   irq_clear_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !(|(evt & mask)) |=> !irq)
      else $error("interrupt raised with no unmasked event");

   rdata_idle_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !reg_rd |=> reg_rdata == IFC_RD_ZERO)
      else $error("read data not zero outside a read");

   flag_read_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      reg_rd && sel_flag
      |=> reg_rdata[NL-1:0] == $past(line_request_flag))
      else $error("flag read returned wrong value");

   unmapped_rd_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      reg_rd && !sel_flag && !sel_sense && !sel_evt && !sel_mask
      |=> reg_rdata == IFC_RD_ZERO)
      else $error("unmapped read not zero");

endmodule

// [bench/ifc_far_model.sv]
// stand-in for the exception sequencer and the transfer controller
`timescale 1ns/100ps
module ifc_far_model
(
   // clock
   input  wire logic core_clk,
   // far side events
   output logic       exc_take,
   output logic [2:0] exc_line,
   output logic       dtc_act,
   output logic [2:0] dtc_line,
   output logic       transfer_interrupt_select
);
   initial
   begin
      exc_take = 1'h0;
      exc_line = 3'h7;
      dtc_act = 1'h0;
      dtc_line = 3'h7;
      transfer_interrupt_select = 1'h1;
   end
   // one-cycle event; indices inverted after it so no stale value lingers
   task automatic fire(input logic data_transfer_controller, input logic [2:0] ln,
                       input logic sel);
      @(posedge core_clk);
      exc_take <= !data_transfer_controller;
      dtc_act <= data_transfer_controller;
      exc_line <= ln;
      dtc_line <= ln;
      transfer_interrupt_select <= sel;
      @(posedge core_clk);
      exc_take <= 1'h0;
      dtc_act <= 1'h0;
      exc_line <= ~ln;
      dtc_line <= ~ln;
      transfer_interrupt_select <= ~sel;
   endtask
endmodule

// [bench/ifc_flag_clear_tb.sv]
// self-checking bench for the interrupt request flag block
`timescale 1ns/100ps
module ifc_flag_clear_tb;
   import ifc_pkg::*;
   typedef struct packed
   {
      logic [1:0] mode;
      logic       post;
      logic [1:0] act;
      logic       exp;
   } ifc_row_s;
   logic        core_clk, rst_b, hw_standby, reg_wr, reg_rd, irq;
   logic        exc_take, dtc_act, sel, pre;
   logic [2:0]  exc_line, dtc_line;
   logic [7:0]  external_interrupt_line, reg_addr, line_request_flag;
   logic [31:0] reg_wdata, reg_rdata, d;
   int          num_errors, checks_done;
   ifc_row_s    r;
   // act: 0 exception, 1 transfer clearing, 2 transfer keeping, 3 software
   ifc_row_s    rows [8] = '{
      '{2'h0, 1'h1, 2'h0, 1'h0},
      '{2'h0, 1'h0, 2'h0, 1'h1},
      '{2'h1, 1'h0, 2'h0, 1'h0},
      '{2'h2, 1'h1, 2'h0, 1'h0},
      '{2'h3, 1'h0, 2'h0, 1'h0},
      '{2'h1, 1'h0, 2'h1, 1'h0},
      '{2'h2, 1'h1, 2'h3, 1'h0},
      '{2'h1, 1'h0, 2'h2, 1'h1}};

   ifc_flag_clear u_ifc_flag_clear (.core_clk(core_clk), .rst_b(rst_b),
      .hw_standby(hw_standby),
      .external_interrupt_line(external_interrupt_line),
      .exc_take(exc_take), .exc_line(exc_line), .dtc_act(dtc_act),
      .dtc_line(dtc_line), .transfer_interrupt_select(sel),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .line_request_flag(line_request_flag), .irq(irq));
   ifc_far_model u_ifc_far_model (.core_clk(core_clk),
      .exc_take(exc_take), .exc_line(exc_line), .dtc_act(dtc_act),
      .dtc_line(dtc_line), .transfer_interrupt_select(sel));

   initial
   begin
      core_clk = 1'h0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      @(posedge core_clk);
      reg_wr <= 1'h0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 v = reg_rdata;
   endtask
   // a zero write only works after a read that saw the flag set
   task automatic sw_clear;
      rd(IFC_A_FLAG, d);
      wr(IFC_A_FLAG, 32'h0);
   endtask
   // pins change by non-blocking assignment at a rising edge
   task automatic pin0(input logic v);
      @(posedge core_clk);
      external_interrupt_line[0] <= v;
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge core_clk);
      num_errors++;
      report_and_stop();
   end
   initial
   begin
      rst_b = 1'h0;
      hw_standby = 1'h0;
      external_interrupt_line = 8'hFF;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      repeat (16) @(posedge core_clk);
      rst_b <= 1'h1;
      #1 chk(line_request_flag, 8'h00);
      chk(irq, 1'h0);
      chk(reg_rdata, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         r = rows[i];
         pre = (r.mode != 2'h2);
         pin0(pre);
         repeat (4) @(posedge core_clk);
         wr(IFC_A_SENSE, {30'h0, r.mode});
         sw_clear();
         pin0(!pre);
         repeat (4) @(posedge core_clk);
         #1 chk(line_request_flag, 8'h01);
         pin0(r.post);
         repeat (4) @(posedge core_clk);
         case (r.act)
            2'h0: u_ifc_far_model.fire(1'h0, 3'h0, 1'h0);
            2'h1: u_ifc_far_model.fire(1'h1, 3'h0, 1'h0);
            2'h2: u_ifc_far_model.fire(1'h1, 3'h0, 1'h1);
            default: sw_clear();
         endcase
         #1 chk(line_request_flag, {7'h00, r.exp});
         $display("test row %0d done", i);
      end
      wr(IFC_A_FLAG, 32'h0);
      chk(line_request_flag, 8'h01);
      rd(IFC_A_FLAG, d);
      chk(d, 32'h1);
      // a write of the flag register in between disarms, so the later zero must not clear
      wr(IFC_A_FLAG, 32'hFF);
      wr(IFC_A_FLAG, 32'h0);
      chk(line_request_flag, 8'h01);
      sw_clear();
      chk(line_request_flag, 8'h00);
      $display("test software clear done");
      rd(IFC_A_EVT, d);
      wr(IFC_A_MASK, 32'h1);
      pin0(1'h1);
      repeat (4) @(posedge core_clk);
      pin0(1'h0);
      repeat (6) @(posedge core_clk);
      #1 chk(irq, 1'h1);
      wr(IFC_A_MASK, 32'h0);
      @(posedge core_clk);
      #1 chk(irq, 1'h0);
      wr(IFC_A_MASK, 32'h1);
      rd(IFC_A_EVT, d);
      chk(d, 32'h1);
      repeat (2) @(posedge core_clk);
      #1 chk(irq, 1'h0);
      rd(8'h10, d);
      chk(d, 32'h0);
      $display("test interrupt done");
      @(posedge core_clk);
      hw_standby <= 1'h1;
      repeat (4) @(posedge core_clk);
      #1 chk(line_request_flag, 8'h00);
      @(posedge core_clk);
      hw_standby <= 1'h0;
      $display("test standby done");
      wr(IFC_A_SENSE, 32'hFFFF);
      rd(IFC_A_SENSE, d);
      chk(d, 32'hFFFF);
      @(posedge core_clk);
      rst_b <= 1'h0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'h1;
      rd(IFC_A_SENSE, d);
      chk(d, 32'h0);
      rd(IFC_A_MASK, d);
      chk(d, 32'h0);
      $display("test reset done");
      report_and_stop();
   end
endmodule
